// ===== core/ictmr_params.svh
`ifndef ICTMR_PARAMS_SVH
`define ICTMR_PARAMS_SVH

`define ICT_OFF_CLK_CTRL   12'h000
`define ICT_OFF_MODE_CTRL  12'h004
`define ICT_OFF_LIVE_LO    12'h008
`define ICT_OFF_LIVE_HI    12'h00C
`define ICT_OFF_CAPT_LO    12'h010
`define ICT_OFF_CAPT_HI    12'h014
`define ICT_OFF_STATUS     12'h018

`define ICT_CLKSEL_LSB     4
`define ICT_RUN_BIT        3
`define ICT_WINSEL_LSB     0
`define ICT_MODE_LSB       6
`define ICT_EDGE_LSB       4
`define ICT_FLAG_BIT       0

`define ICT_CS_SYS_DIV4    3'h0
`define ICT_CS_SYS         3'h1
`define ICT_CS_HS_DIV16    3'h2
`define ICT_CS_HS_DIV64    3'h3
`define ICT_CS_SLOW_A      3'h4
`define ICT_CS_SLOW_B      3'h5
`define ICT_CS_EXT_RISE    3'h6
`define ICT_CS_EXT_FALL    3'h7

`define ICT_EDGE_RISE      2'h0
`define ICT_EDGE_FALL      2'h1
`define ICT_EDGE_BOTH      2'h2

`define ICT_SYS_DIV_LAST   2'h3
`define ICT_HS16_MASK      6'h0F
`define ICT_HS64_MASK      6'h3F
`define ICT_WIN_BASE_LOG2  13
`define ICT_RESET_BYTE     8'h00

`endif

// ===== core/ictmr_pkg.sv
package ictmr_pkg;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } ictmr_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } ictmr_apb_rsp_t;

   typedef struct packed {
      logic [2:0]     clk_sel;
      logic           run;
      logic [2:0]     win_sel;
      logic [1:0]     mode;
      logic [1:0]     edge_sel;
      logic [9:0]     count;
      logic [9:0]     captured;
      logic           flag;
      logic [1:0]     sys_div;
      logic [5:0]     hs_div;
      logic [19:0]    win_cnt;
      logic           ext_d;
      logic           phase_d;
      ictmr_apb_rsp_t rsp;
   } ictmr_state_t;

endpackage

// ===== core/ictmr_top.sv
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
`include "ictmr_params.svh"
// Notes on behaviour
// - Three-bit field picks counter tick source among eight codes; codes 4 and 5 both pick the slow tick.
// - Counter advances only while run bit is one; off means frozen.
// - Run bit rising clears live counter and captured count.
// - Run bit falling holds counter and captured count unchanged.
// - Window length is PWM clock over 8192 doubling up to 1048576.
// - Window elapse copies counter to captured count, sets done flag.
// - Mode codes 00/01 mean capture input, 10/11 timer/counter.
// - Capture edge: 00 rising, 01 falling, 10 both, 11 disabled.
// - Edge selection has no effect in timer/counter mode.
// - Live count readable as low byte and two-bit high byte.
// - Captured count low byte is read-only and resets to zero.
// - Captured count high byte holds bits 9..8, rest read zero.
// - Unused mode-control low nibble and clock-control bit 7 read zero.
module ictmr_top #(
   parameter int unsigned WIN_BASE_LOG2 = `ICT_WIN_BASE_LOG2
) (
   input  wire logic                    i_clk,
   input  wire logic                    i_srst,
   input  wire ictmr_pkg::ictmr_apb_req_t i_apb,
   output ictmr_pkg::ictmr_apb_rsp_t    o_apb,
   input  wire logic                    i_high_speed_clock_tick,
   input  wire logic                    i_slow_clock_tick,
   input  wire logic                    i_pwm_clock_tick,
   input  wire logic                    i_external_count_clock,
   input  wire logic                    i_phase,
   output logic                         o_window_done_flag,
   output logic [9:0]                   o_captured_count
);

   ictmr_pkg::ictmr_state_t st_reg;
   ictmr_pkg::ictmr_state_t st_next;

   logic        setup;
   logic        access;
   logic        wr_clk;
   logic        wr_mode;
   logic        wr_stat;
   logic        run_set;
   logic        tick;
   logic        ext_rise;
   logic        ext_fall;
   logic        ph_rise;
   logic        ph_fall;
   logic        ph_hit;
   logic        win_hit;
   logic [19:0] win_mask;
   logic [31:0] rd_data;
   logic        rd_err;

   assign setup    = i_apb.psel && !i_apb.penable && !st_reg.rsp.pready;
   assign access   = i_apb.psel && i_apb.penable && st_reg.rsp.pready;
   assign wr_clk   = access && i_apb.pwrite && (i_apb.paddr == `ICT_OFF_CLK_CTRL);
   assign wr_mode  = access && i_apb.pwrite && (i_apb.paddr == `ICT_OFF_MODE_CTRL);
   assign wr_stat  = access && i_apb.pwrite && (i_apb.paddr == `ICT_OFF_STATUS);
   assign run_set  = wr_clk && i_apb.pwdata[`ICT_RUN_BIT] && !st_reg.run;
   assign ext_rise = i_external_count_clock && !st_reg.ext_d;
   assign ext_fall = !i_external_count_clock && st_reg.ext_d;
   assign ph_rise  = i_phase && !st_reg.phase_d;
   assign ph_fall  = !i_phase && st_reg.phase_d;
   // Window end is the all-ones point of the selected low bits of the PWM tick count
   assign win_mask = ~(20'hFFFFF << (WIN_BASE_LOG2 + 32'(st_reg.win_sel)));
   assign win_hit  = st_reg.run && i_pwm_clock_tick
                     && ((st_reg.win_cnt & win_mask) == win_mask);

   always_comb
   begin
      tick = 1'b0;
      case (st_reg.clk_sel)
         `ICT_CS_SYS_DIV4 : tick = (st_reg.sys_div == `ICT_SYS_DIV_LAST);
         `ICT_CS_SYS      : tick = 1'b1;
         `ICT_CS_HS_DIV16 : tick = i_high_speed_clock_tick
                                   && ((st_reg.hs_div & `ICT_HS16_MASK) == `ICT_HS16_MASK);
         `ICT_CS_HS_DIV64 : tick = i_high_speed_clock_tick
                                   && (st_reg.hs_div == `ICT_HS64_MASK);
         `ICT_CS_SLOW_A   : tick = i_slow_clock_tick;
         `ICT_CS_SLOW_B   : tick = i_slow_clock_tick;
         `ICT_CS_EXT_RISE : tick = ext_rise;
         `ICT_CS_EXT_FALL : tick = ext_fall;
         default          : tick = 1'b0;
      endcase
   end

   always_comb
   begin
      ph_hit = 1'b0;
      if (!st_reg.mode[1])
      begin
         case (st_reg.edge_sel)
            `ICT_EDGE_RISE : ph_hit = ph_rise;
            `ICT_EDGE_FALL : ph_hit = ph_fall;
            `ICT_EDGE_BOTH : ph_hit = ph_rise || ph_fall;
            default        : ph_hit = 1'b0;
         endcase
      end
   end

   always_comb
   begin
      rd_data = 32'h0000_0000;
      rd_err  = 1'b0;
      case (i_apb.paddr)
         `ICT_OFF_CLK_CTRL  : rd_data = {24'h000000, 1'b0, st_reg.clk_sel, st_reg.run,
                                         st_reg.win_sel};
         `ICT_OFF_MODE_CTRL : rd_data = {24'h000000, st_reg.mode, st_reg.edge_sel,
                                         4'h0};
         `ICT_OFF_LIVE_LO   : rd_data = {24'h000000, st_reg.count[7:0]};
         `ICT_OFF_LIVE_HI   : rd_data = {30'h00000000, st_reg.count[9:8]};
         `ICT_OFF_CAPT_LO   : rd_data = {24'h000000, st_reg.captured[7:0]};
         `ICT_OFF_CAPT_HI   : rd_data = {30'h00000000, st_reg.captured[9:8]};
         `ICT_OFF_STATUS    : rd_data = {31'h00000000, st_reg.flag};
         default            : rd_err  = 1'b1;
      endcase
   end

   always_comb
   begin
      st_next         = st_reg;
      st_next.ext_d   = i_external_count_clock;
      st_next.phase_d = i_phase;

      // Registered answer: pready rises in the first access cycle, so no wait states
      st_next.rsp.pready = setup;
      if (setup)
      begin
         st_next.rsp.prdata  = i_apb.pwrite ? 32'h0000_0000 : rd_data;
         st_next.rsp.pslverr = rd_err;
      end
      else if (access)
      begin
         st_next.rsp.prdata  = 32'h0000_0000;
         st_next.rsp.pslverr = 1'b0;
      end

      // Dividers and window sit idle while off, which is the power-down
      if (st_reg.run)
      begin
         st_next.sys_div = st_reg.sys_div + 2'h1;
         if (i_high_speed_clock_tick)
         begin
            st_next.hs_div = st_reg.hs_div + 6'h01;
         end
         if (i_pwm_clock_tick)
         begin
            st_next.win_cnt = st_reg.win_cnt + 20'h00001;
         end
         if (tick)
         begin
            st_next.count = st_reg.count + 10'h001;
         end
         // Window copy takes priority over a phase capture in the same cycle
         if (win_hit)
         begin
            st_next.captured = st_reg.count;
         end
         else if (ph_hit)
         begin
            st_next.captured = st_reg.count;
         end
      end

      // Clear before set, so a window end in the clearing cycle is kept
      if (wr_stat && i_apb.pwdata[`ICT_FLAG_BIT])
      begin
         st_next.flag = 1'b0;
      end
      if (win_hit)
      begin
         st_next.flag = 1'b1;
      end

      if (wr_clk)
      begin
         st_next.clk_sel = i_apb.pwdata[`ICT_CLKSEL_LSB +: 3];
         st_next.run     = i_apb.pwdata[`ICT_RUN_BIT];
         st_next.win_sel = i_apb.pwdata[`ICT_WINSEL_LSB +: 3];
      end
      if (wr_mode)
      begin
         st_next.mode     = i_apb.pwdata[`ICT_MODE_LSB +: 2];
         st_next.edge_sel = i_apb.pwdata[`ICT_EDGE_LSB +: 2];
      end
      if (run_set)
      begin
         st_next.count    = 10'h000;
         st_next.captured = 10'h000;
         st_next.sys_div  = 2'h0;
         st_next.hs_div   = 6'h00;
         st_next.win_cnt  = 20'h00000;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign o_apb              = st_reg.rsp;
   assign o_window_done_flag = st_reg.flag;
   assign o_captured_count   = st_reg.captured;

   property p_run_rise_clears;
      @(posedge i_clk) disable iff (i_srst)
      run_set |=> (st_reg.count == 10'h000) && (st_reg.captured == 10'h000);
   endproperty
   a_run_rise_clears: assert property (p_run_rise_clears)
      else $error("run rise did not clear counts");

   property p_off_holds;
      @(posedge i_clk) disable iff (i_srst)
      (!st_reg.run && !run_set) |=> $stable(st_reg.count) && $stable(st_reg.captured);
   endproperty
   a_off_holds: assert property (p_off_holds)
      else $error("counts moved while stopped");

   property p_sys_tick;
      @(posedge i_clk) disable iff (i_srst)
      (st_reg.run && st_reg.clk_sel == `ICT_CS_SYS && !run_set)
      |=> st_reg.count == 10'($past(st_reg.count) + 10'h001);
   endproperty
   a_sys_tick: assert property (p_sys_tick)
      else $error("counter missed system tick");

   property p_div4_tick;
      @(posedge i_clk) disable iff (i_srst)
      (st_reg.run && st_reg.clk_sel == `ICT_CS_SYS_DIV4 && !wr_clk) [*5]
      |-> st_reg.count == 10'($past(st_reg.count, 4) + 10'h001);
   endproperty
   a_div4_tick: assert property (p_div4_tick)
      else $error("divide by four rate wrong");

   property p_window_copy;
      @(posedge i_clk) disable iff (i_srst)
      (win_hit && !run_set) |=> st_reg.flag && (st_reg.captured == $past(st_reg.count));
   endproperty
   a_window_copy: assert property (p_window_copy)
      else $error("window end did not capture");

   property p_timer_mode_no_capture;
      @(posedge i_clk) disable iff (i_srst)
      (st_reg.mode[1] && !win_hit && !run_set) |=> $stable(st_reg.captured);
   endproperty
   a_timer_mode_no_capture: assert property (p_timer_mode_no_capture)
      else $error("phase capture in timer mode");

   property p_phase_rise_capture;
      @(posedge i_clk) disable iff (i_srst)
      (st_reg.run && !st_reg.mode[1] && st_reg.edge_sel == `ICT_EDGE_RISE && ph_rise
       && !win_hit && !run_set) |=> st_reg.captured == $past(st_reg.count);
   endproperty
   a_phase_rise_capture: assert property (p_phase_rise_capture)
      else $error("rising phase edge not captured");

   property p_mode_low_zero;
      @(posedge i_clk) disable iff (i_srst)
      (setup && !i_apb.pwrite && i_apb.paddr == `ICT_OFF_MODE_CTRL)
      |=> o_apb.pready && (o_apb.prdata[3:0] == 4'h0) && !o_apb.pslverr;
   endproperty
   a_mode_low_zero: assert property (p_mode_low_zero)
      else $error("mode control low nibble not zero");

   property p_capt_hi_read;
      @(posedge i_clk) disable iff (i_srst)
      (setup && !i_apb.pwrite && i_apb.paddr == `ICT_OFF_CAPT_HI)
      |=> o_apb.prdata == {30'h00000000, $past(st_reg.captured[9:8])};
   endproperty
   a_capt_hi_read: assert property (p_capt_hi_read)
      else $error("captured high byte read wrong");

   property p_live_lo_read;
      @(posedge i_clk) disable iff (i_srst)
      (setup && !i_apb.pwrite && i_apb.paddr == `ICT_OFF_LIVE_LO)
      |=> o_apb.prdata == {24'h000000, $past(st_reg.count[7:0])};
   endproperty
   a_live_lo_read: assert property (p_live_lo_read)
      else $error("live low byte read wrong");

   property p_live_hi_read;
      @(posedge i_clk) disable iff (i_srst)
      (setup && !i_apb.pwrite && i_apb.paddr == `ICT_OFF_LIVE_HI)
      |=> o_apb.prdata == {30'h00000000, $past(st_reg.count[9:8])};
   endproperty
   a_live_hi_read: assert property (p_live_hi_read)
      else $error("live high byte read wrong");

   property p_flag_clear;
      @(posedge i_clk) disable iff (i_srst)
      (wr_stat && i_apb.pwdata[`ICT_FLAG_BIT] && !win_hit) |=> !st_reg.flag;
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("done flag not cleared");

endmodule

// ===== testbench/ictmr_far_end.sv
`timescale 1ns/1ps
// Far-side model: external count clock and phase-sense source
module ictmr_far_end (
   input  wire logic i_clk,
   input  wire logic i_srst,
   input  wire logic i_ext_req,
   input  wire logic i_phase_flip,
   output logic      o_external_count_clock,
   output logic      o_phase
);
   logic [1:0] pulse_reg;
   // Count clock rests low between bursts, so one request is one rise and one fall
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         pulse_reg <= 2'h0;
         o_phase   <= 1'b0;
      end
      else
      begin
         pulse_reg <= i_ext_req ? 2'h2 : pulse_reg - {1'b0, pulse_reg != 2'h0};
         o_phase   <= o_phase ^ i_phase_flip;
      end
   end
   assign o_external_count_clock = (pulse_reg != 2'h0);
endmodule

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
`include "ictmr_params.svh"
module tb_top;
   localparam int WB = 3;
   typedef struct { logic [2:0] sel; int kind; int n; logic [9:0] ex; } ictmr_row_t;
   ictmr_row_t rows [6] = '{'{3'h2, 0, 32, 10'h002}, '{3'h3, 0, 128, 10'h002},
      '{3'h4, 1, 260, 10'h104}, '{3'h5, 1, 1027, 10'h003},
      '{3'h6, 3, 3, 10'h003}, '{3'h7, 3, 3, 10'h003}};
   logic                      clk = 1'b0;
   logic                      srst = 1'b1;
   ictmr_pkg::ictmr_apb_req_t req = '0;
   ictmr_pkg::ictmr_apb_rsp_t rsp;
   logic                      hs_tick = 1'b0;
   logic                      sl_tick = 1'b0;
   logic                      pwm_tick = 1'b0;
   logic                      ext_req = 1'b0;
   logic                      ph_flip = 1'b0;
   logic                      ext_clk;
   logic                      phase;
   logic                      flag;
   logic [9:0]                capt;
   logic [31:0]               rd;
   logic                      err;
   int                        n_mismatch = 0;
   int                        samples_checked = 0;
   int                        cycles = 0;

   always #12.5 clk = ~clk;

   ictmr_top #(.WIN_BASE_LOG2(WB)) dut_u (.i_clk(clk), .i_srst(srst), .i_apb(req),
      .o_apb(rsp), .i_high_speed_clock_tick(hs_tick), .i_slow_clock_tick(sl_tick),
      .i_pwm_clock_tick(pwm_tick), .i_external_count_clock(ext_clk), .i_phase(phase),
      .o_window_done_flag(flag), .o_captured_count(capt));
   ictmr_far_end far_u (.i_clk(clk), .i_srst(srst), .i_ext_req(ext_req),
      .i_phase_flip(ph_flip), .o_external_count_clock(ext_clk), .o_phase(phase));

   task results;
      $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Whole run needs under ten thousand cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         results();
      end
   end

   task chk(input logic [31:0] got, input logic [31:0] ex);
      samples_checked++;
      if (got !== ex)
      begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, ex);
      end
   endtask

   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      req <= '{1'b1, 1'b0, wr, a, d};
      @(posedge clk);
      req.penable <= 1'b1;
      @(posedge clk);
      while (rsp.pready !== 1'b1)
         @(posedge clk);
      rd = rsp.prdata;
      err = rsp.pslverr;
      // Idle cycle between transfers, so no request field is updated twice in one step
      req <= '0;
      @(posedge clk);
   endtask

   task pulse(input int k, input int n);
      repeat (n)
      begin
         case (k)
            0: hs_tick <= 1'b1;
            1: sl_tick <= 1'b1;
            2: pwm_tick <= 1'b1;
            3: ext_req <= 1'b1;
            default: ph_flip <= 1'b1;
         endcase
         @(posedge clk);
         {hs_tick, sl_tick, pwm_tick, ext_req, ph_flip} <= 5'h00;
         @(posedge clk);
         if (k > 2)
            repeat (4) @(posedge clk);
      end
   endtask

   initial
   begin
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      for (int a = 0; a < 7; a++)
      begin
         apb(1'b0, 12'(a * 4), 32'h0);
         chk(rd, 32'h0);
      end
      foreach (rows[r])
      begin
         apb(1'b1, `ICT_OFF_CLK_CTRL, {25'h0, rows[r].sel, 4'hF});
         pulse(rows[r].kind, rows[r].n);
         apb(1'b1, `ICT_OFF_CLK_CTRL, {25'h0, rows[r].sel, 4'h7});
         pulse(rows[r].kind, 2);
         apb(1'b0, `ICT_OFF_LIVE_LO, 32'h0);
         chk(rd, {24'h0, rows[r].ex[7:0]});
         apb(1'b0, `ICT_OFF_LIVE_HI, 32'h0);
         chk(rd, {30'h0, rows[r].ex[9:8]});
      end
      for (int s = 0; s < 2; s++)
      begin
         apb(1'b1, `ICT_OFF_CLK_CTRL, 32'h18 - 32'(s * 16));
         repeat (40) @(posedge clk);
         apb(1'b1, `ICT_OFF_CLK_CTRL, 32'h10 - 32'(s * 16));
         apb(1'b0, `ICT_OFF_LIVE_LO, 32'h0);
         chk(32'(s ? (rd >= 9 && rd <= 12) : (rd >= 40 && rd <= 46)), 32'h1);
      end
      apb(1'b1, `ICT_OFF_MODE_CTRL, 32'h80);
      for (int s = 0; s < 3; s++)
      begin
         apb(1'b1, `ICT_OFF_CLK_CTRL, 32'h48 + 32'(s));
         pulse(1, 3);
         pulse(2, (1 << (WB + s)) - 1);
         chk(flag, 32'h0);
         pulse(2, 1);
         chk(flag, 32'h1);
         chk(capt, 32'h3);
         apb(1'b0, `ICT_OFF_CAPT_LO, 32'h0);
         chk(rd, 32'h3);
         apb(1'b0, `ICT_OFF_CAPT_HI, 32'h0);
         chk(rd, 32'h0);
         apb(1'b1, `ICT_OFF_STATUS, 32'h1);
         apb(1'b0, `ICT_OFF_STATUS, 32'h0);
         chk(rd, 32'h0);
         apb(1'b1, `ICT_OFF_CLK_CTRL, 32'h40);
      end
      pulse(1, 3);
      apb(1'b0, `ICT_OFF_LIVE_LO, 32'h0);
      chk(rd, 32'h3);
      chk(capt, 32'h3);
      apb(1'b1, `ICT_OFF_CLK_CTRL, 32'hFF);
      apb(1'b0, `ICT_OFF_CLK_CTRL, 32'h0);
      chk(rd, 32'h7F);
      apb(1'b0, `ICT_OFF_CAPT_LO, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, `ICT_OFF_LIVE_LO, 32'hFF);
      apb(1'b0, `ICT_OFF_LIVE_LO, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, `ICT_OFF_CLK_CTRL, 32'h40);
      for (int m = 0; m < 4; m++)
         for (int e = 0; e < 4; e++)
         begin
            apb(1'b1, `ICT_OFF_MODE_CTRL, {24'h0, 2'(m), 2'(e), 4'h0});
            apb(1'b1, `ICT_OFF_CLK_CTRL, 32'h48);
            pulse(1, 4);
            pulse(4, 1);
            pulse(1, 2);
            pulse(4, 1);
            chk(capt, (m > 1 || e == 3) ? 32'h0 : (e == 0 ? 32'h4 : 32'h6));
            apb(1'b1, `ICT_OFF_CLK_CTRL, 32'h40);
         end
      apb(1'b1, `ICT_OFF_MODE_CTRL, 32'hFF);
      apb(1'b0, `ICT_OFF_MODE_CTRL, 32'h0);
      chk(rd, 32'hF0);
      apb(1'b0, 12'h01C, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      apb(1'b0, `ICT_OFF_MODE_CTRL, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, `ICT_OFF_CLK_CTRL, 32'h0);
      chk(rd, 32'h0);
      results();
   end
endmodule
